// ### axis_param_map.vh
// Register numbers, field positions, reset values and timing for the axis block
`ifndef AXIS_PARAM_MAP_VH
`define AXIS_PARAM_MAP_VH
`define REG_BOOST_CUR 8'hc8
`define REG_FREEWHEEL 8'hcc
`define REG_LOAD 8'hce
`define REG_ERRFLAGS 8'hcf
`define REG_DRVSTAT 8'hd0
`define REG_ENC_COUNT 8'hd1
`define REG_ENC_SCALE 8'hd2
`define REG_MAX_DEV 8'hd4
`define FREEWHEEL_RST 16'h0000
`define ERR_STALL_BIT 0
`define ERR_DEV_BIT 1
`define FREEWHEEL_UNIT_MS 10
`define CLK_HZ 25000000
`define STANDSTILL_LOG2 20
`endif

// ### axis_params_monitor.sv
// Port assertions for the axis parameter block
`timescale 1ns/1ns
`default_nettype none
module axis_params_monitor (
	input wire logic sys_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic par_rd, // Read
	input wire logic [7:0] par_num, // Number
	input wire logic [31:0] par_rdata_ff, // Read data
	input wire logic ramping, // Ramp phase
	input wire logic vel_zero, // Stopped
	input wire logic [7:0] run_current, // Run current
	input wire logic [9:0] stall_load, // Load
	input wire logic [6:0] drv_flags, // Driver flags
	input wire logic step_pulse, // Step
	input wire logic [7:0] motor_current_ff, // Current out
	input wire logic power_cut_ff, // Power cut
	input wire logic dev_stop_ff // Deviation stop
);
	// Answers tied to their causes
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_run_cur: assert property (
		!ramping |=> motor_current_ff == $past(run_current))
		else $error("bad current");
	a_cut_moving: assert property (
		!vel_zero |=> !power_cut_ff) else $error("cut while moving");
	a_rd_hold: assert property (
		!par_rd |=> $stable(par_rdata_ff)) else $error("read data moved");
	a_load_rd: assert property (
		par_rd && par_num == 8'hce |=> par_rdata_ff == {22'h0, $past(stall_load)})
		else $error("bad load");
	a_stat_rd: assert property (
		par_rd && par_num == 8'hd0 |=> par_rdata_ff[6:0] == $past(drv_flags))
		else $error("bad status");
	a_moving_bit: assert property (
		par_rd && par_num == 8'hd0 && $past(step_pulse) |=> !par_rdata_ff[7])
		else $error("bad standstill");
	a_err_rd: assert property (
		par_rd && par_num == 8'hcf |=> par_rdata_ff[31:2] == 0)
		else $error("bad flags");
	a_dev_pulse: assert property (
		dev_stop_ff |=> !dev_stop_ff) else $error("stop not a pulse");
endmodule
`default_nettype wire

// ### drive_stage_model.sv
// Driver stage and encoder stand-in
`timescale 1ns/1ns
`default_nettype none
module drive_stage_model (
	input wire logic sys_clk, // Clock
	input wire logic enc_go, // Turn shaft up
	input wire logic [6:0] faults, // Fault states
	output logic [9:0] stall_load, // Load
	output logic [6:0] drv_flags, // Flags
	output logic enc_step_ff, // Encoder step
	output logic enc_dir // Direction
);
	// Driver flags follow faults; load and direction are fixed
	assign stall_load = 10'h2a5;
	assign drv_flags = faults;
	assign enc_dir = 1'b1;
	// One step every other cycle
	always @(posedge sys_clk) begin
		enc_step_ff <= enc_go & ~enc_step_ff;
	end
endmodule
`default_nettype wire

// ### enc_prescaler.v
// Encoder step prescaler: accumulates scaled encoder steps
`timescale 1ns/1ns
`default_nettype none
module enc_prescaler (
	input wire sys_clk, // Clock
	input wire rst_n, // Sync reset, active low
	input wire enc_step, // One encoder step, pulse
	input wire enc_dir, // 1 = up, 0 = down
	input wire [31:0] scale, // Step weight, 16.16 fixed point, weights of 1.0 and above act as 1.0
	output wire adv, // Count advance, pulse
	output wire adv_dir // Direction of advance
);
	reg [15:0] frac_ff;
	wire [16:0] sum;
	wire [15:0] whole;
	assign sum = {1'b0, frac_ff} + {1'b0, scale[15:0]};
	assign whole = scale[31:16];
	// Fractional carry or integer part of scale gives an advance
	assign adv = enc_step & (sum[16] | (whole != 16'h0000));
	assign adv_dir = enc_dir;
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			frac_ff <= 16'h0000;
		end else if (enc_step) begin
			frac_ff <= sum[15:0];
		end
	end
endmodule
`default_nettype wire

// ### stepper_axis_status_params.v
// Per-axis parameter and status block of a stepper controller
//
// Overview of operation
// RQ1: Ramp phases use boost current, else run current
// RQ2: Boost current is 0..255, run-current scaling
// RQ3: Cut power freewheel delay after velocity zero
// RQ4: Zero delay disables cut; resets to zero
// RQ5: Stall load readable, 0..1023
// RQ6: Error word: 1 stall, 2 deviation
// RQ7: Read or motion command clears error flags
// RQ8: Status bit 0: stall threshold reached
// RQ9: Bits 1,2: overtemp shutdown, pre-warning
// RQ10: Bits 3,4: coil short while shut down
// RQ11: Bits 5,6: open load per coil
// RQ12: Bit 7: no step for 2^20 cycles
// RQ13: Stop and flag on excess deviation
// RQ14: Signed 32-bit encoder count, prescaled
`timescale 1ns/1ns
`default_nettype none
`include "axis_param_map.vh"
module stepper_axis_status_params #(
	parameter STANDSTILL_CYCLES = 1 << `STANDSTILL_LOG2, // Idle step window
	parameter TICK_CYCLES = `CLK_HZ / 1000 * `FREEWHEEL_UNIT_MS // 10 ms
) (
	input wire sys_clk, // Clock, 25 MHz
	input wire rst_n, // Sync reset, active low
	input wire par_wr, // Parameter write, pulse
	input wire par_rd, // Parameter read, pulse
	input wire [7:0] par_num, // Parameter number
	input wire [31:0] par_wdata, // Write data
	output reg [31:0] par_rdata_ff, // Read data, valid cycle after read
	input wire motion_cmd, // Motion command executed, pulse
	input wire ramping, // Accelerating or decelerating
	input wire vel_zero, // Velocity is zero
	input wire [7:0] run_current, // Normal maximum run current
	input wire [31:0] cmd_position, // Commanded position
	input wire [9:0] stall_load, // Stall measurement
	input wire stall_event, // Stall error detected, pulse
	input wire [6:0] drv_flags, // Driver flags, bits 0..6
	input wire step_pulse, // Step pulse to driver
	input wire enc_step, // Encoder step, pulse
	input wire enc_dir, // Encoder direction, 1 = up
	output reg [7:0] motor_current_ff, // Current setting to driver
	output reg power_cut_ff, // Motor power cut
	output reg dev_stop_ff // Stop motor on deviation, pulse
);
	reg [7:0] boost_ff;
	reg [15:0] freewheel_ff;
	reg [1:0] err_ff;
	reg [31:0] enc_ff;
	reg [31:0] scale_ff;
	reg [31:0] max_dev_ff;
	reg [19:0] idle_cnt_ff;
	reg standstill_ff;
	reg [23:0] tick_cnt_ff;
	reg [15:0] fw_cnt_ff;
	wire adv;
	wire adv_dir;
	wire [31:0] diff;
	wire [31:0] abs_diff;
	wire dev_err;
	wire clr_err;
	wire [7:0] status;
	// Last count of each timer, kept 32 bits wide before the slice
	localparam [31:0] IDLE_LAST = STANDSTILL_CYCLES - 1;
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	// Decode a parameter number
	function is_num;
		input [7:0] num;
		input [7:0] target;
		begin
			is_num = (num == target);
		end
	endfunction

	enc_prescaler u_pre (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enc_step(enc_step),
		.enc_dir(enc_dir),
		.scale(scale_ff),
		.adv(adv),
		.adv_dir(adv_dir)
	);

	// Driver status word, flags straight through, standstill on top
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_stat
			assign status[gi] = drv_flags[gi]; // RQ8 RQ9 RQ10 RQ11
		end
	endgenerate
	assign status[7] = standstill_ff; // RQ12
	// Deviation check on the distance between command and encoder
	// Distance wraps once the two are more than 2^31 apart
	assign diff = cmd_position - enc_ff;
	assign abs_diff = diff[31] ? (32'h0000_0000 - diff) : diff;
	// A limit of zero switches the check off
	assign dev_err = (max_dev_ff != 32'h0000_0000) &&
		(abs_diff > max_dev_ff); // RQ13
	// Reading the error word or a motion command clears the flags
	assign clr_err = (par_rd && is_num(par_num, `REG_ERRFLAGS)) || motion_cmd;

	// Writable parameters and encoder counter
	// Writes to read-only numbers fall through and are dropped
	// A host write to the count wins over a step in the same cycle
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			boost_ff <= 8'h00;
			freewheel_ff <= `FREEWHEEL_RST; // RQ4
			scale_ff <= 32'h0001_0000;
			max_dev_ff <= 32'h0000_0000;
			enc_ff <= 32'h0000_0000;
		end else begin
			if (par_wr && is_num(par_num, `REG_BOOST_CUR))
				boost_ff <= par_wdata[7:0]; // RQ2
			if (par_wr && is_num(par_num, `REG_FREEWHEEL))
				freewheel_ff <= par_wdata[15:0];
			if (par_wr && is_num(par_num, `REG_ENC_SCALE))
				scale_ff <= par_wdata;
			if (par_wr && is_num(par_num, `REG_MAX_DEV))
				max_dev_ff <= par_wdata;
			if (par_wr && is_num(par_num, `REG_ENC_COUNT))
				enc_ff <= par_wdata; // RQ14
			else if (adv)
				enc_ff <= adv_dir ? enc_ff + 32'h0000_0001
					: enc_ff - 32'h0000_0001; // RQ14
		end
	end

	// Sticky error flags, a new event wins over the clear
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			err_ff <= 2'b00;
			dev_stop_ff <= 1'b0;
		end else begin
			err_ff[`ERR_STALL_BIT] <= stall_event |
				(err_ff[`ERR_STALL_BIT] & ~clr_err); // RQ6 RQ7
			err_ff[`ERR_DEV_BIT] <= dev_err |
				(err_ff[`ERR_DEV_BIT] & ~clr_err); // RQ6 RQ7 RQ13
			dev_stop_ff <= dev_err & ~err_ff[`ERR_DEV_BIT]; // RQ13
		end
	end

	// Standstill detector on step input
	// Counter parks on its last value, so the flag stays up until a step
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			idle_cnt_ff <= 20'h0_0000;
			standstill_ff <= 1'b0;
		end else if (step_pulse) begin
			idle_cnt_ff <= 20'h0_0000;
			standstill_ff <= 1'b0;
		end else if (idle_cnt_ff == IDLE_LAST[19:0]) begin
			standstill_ff <= 1'b1; // RQ12
		end else begin
			idle_cnt_ff <= idle_cnt_ff + 20'h0_0001;
		end
	end

	// Freewheel timer in 10 ms ticks
	// Restarts whenever the motor moves or the delay is zero
	// Once cut, power stays off until motion resumes or the delay is set to zero
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt_ff <= 24'h00_0000;
			fw_cnt_ff <= 16'h0000;
			power_cut_ff <= 1'b0;
		end else if (!vel_zero || freewheel_ff == 16'h0000) begin
			tick_cnt_ff <= 24'h00_0000; // RQ4
			fw_cnt_ff <= 16'h0000;
			power_cut_ff <= 1'b0;
		end else if (!power_cut_ff) begin
			if (tick_cnt_ff == TICK_LAST[23:0]) begin
				tick_cnt_ff <= 24'h00_0000;
				if (fw_cnt_ff == freewheel_ff - 16'h0001)
					power_cut_ff <= 1'b1; // RQ3
				else
					fw_cnt_ff <= fw_cnt_ff + 16'h0001;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 24'h00_0001;
			end
		end
	end

	// Current selection
	// A boost of zero falls back to the run current
	// One cycle of lag from ramp flag to current output
	always @(posedge sys_clk) begin
		if (!rst_n)
			motor_current_ff <= 8'h00;
		else if (ramping && boost_ff != 8'h00)
			motor_current_ff <= boost_ff; // RQ1
		else
			motor_current_ff <= run_current; // RQ1
	end

	// Read mux
	// Data holds until the next read; unknown numbers read zero
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			par_rdata_ff <= 32'h0000_0000;
		end else if (par_rd) begin
			case (par_num)
			`REG_BOOST_CUR: par_rdata_ff <= {24'h00_0000, boost_ff};
			`REG_FREEWHEEL: par_rdata_ff <= {16'h0000, freewheel_ff};
			`REG_LOAD: par_rdata_ff <= {22'h00_0000, stall_load}; // RQ5
			`REG_ERRFLAGS: par_rdata_ff <= {30'h0000_0000, err_ff}; // RQ6
			`REG_DRVSTAT: par_rdata_ff <= {24'h00_0000, status};
			`REG_ENC_COUNT: par_rdata_ff <= enc_ff;
			`REG_ENC_SCALE: par_rdata_ff <= scale_ff;
			`REG_MAX_DEV: par_rdata_ff <= max_dev_ff;
			default: par_rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### test_stepper_axis_status_params.sv
// Testbench for the axis parameter block
`timescale 1ns/1ns
`default_nettype none
module test_stepper_axis_status_params;
	logic sys_clk = 0, rst_n = 0, par_wr = 0, par_rd = 0, motion_cmd = 0;
	logic ramping = 0, vel_zero = 0, stall_event = 0, step_pulse = 0;
	logic enc_go = 0;
	logic [7:0] par_num = 0, run_current = 0;
	logic [31:0] par_wdata = 0, cmd_position = 0;
	logic [6:0] faults = 0;
	wire [31:0] par_rdata_ff;
	wire [9:0] stall_load;
	wire [6:0] drv_flags;
	wire [7:0] motor_current_ff;
	wire power_cut_ff, dev_stop_ff, enc_step_ff, enc_dir;
	int miscompares = 0, n_checks = 0;
	// Block and far side
	stepper_axis_status_params #(.STANDSTILL_CYCLES(16), .TICK_CYCLES(4)) uut (
		.sys_clk, .rst_n, .par_wr, .par_rd, .par_num, .par_wdata, .par_rdata_ff,
		.motion_cmd, .ramping, .vel_zero, .run_current, .cmd_position,
		.stall_load, .stall_event, .drv_flags, .step_pulse, .enc_step(enc_step_ff),
		.enc_dir, .motor_current_ff, .power_cut_ff, .dev_stop_ff);
	drive_stage_model far (.sys_clk, .enc_go, .faults, .stall_load, .drv_flags,
		.enc_step_ff, .enc_dir);
	initial forever #20 sys_clk = ~sys_clk;
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] n, input logic [31:0] d);
		par_wr <= 1'b1;
		par_num <= n;
		par_wdata <= d;
		cyc(1);
		par_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] n, input logic [31:0] e);
		par_rd <= 1'b1;
		par_num <= n;
		cyc(1);
		par_rd <= 1'b0;
		cyc(1);
		chk(par_rdata_ff, e);
	endtask
	task t_boost;
		run_current <= 8'h30;
		ramping <= 1'b1;
		cyc(2);
		chk({24'h0, motor_current_ff}, 32'h0000_0030);
		wr(8'hc8, 32'h0000_00ff);
		cyc(2);
		chk({24'h0, motor_current_ff}, 32'h0000_00ff);
		ramping <= 1'b0;
		rd(8'hc8, 32'h0000_00ff);
	endtask
	task t_freewheel;
		rd(8'hcc, 32'h0000_0000);
		wr(8'hcc, 32'h0000_0003);
		vel_zero <= 1'b1;
		cyc(6);
		chk({31'h0, power_cut_ff}, 32'h0000_0000);
		cyc(8);
		chk({31'h0, power_cut_ff}, 32'h0000_0001);
		wr(8'hcc, 32'h0000_0000);
		vel_zero <= 1'b0;
		cyc(1);
		vel_zero <= 1'b1;
		cyc(20);
		chk({31'h0, power_cut_ff}, 32'h0000_0000);
		vel_zero <= 1'b0;
	endtask
	task t_status;
		faults <= 7'h55;
		cyc(20);
		rd(8'hd0, 32'h0000_00d5);
		faults <= 7'h2a;
		step_pulse <= 1'b1;
		cyc(1);
		step_pulse <= 1'b0;
		rd(8'hd0, 32'h0000_002a);
		rd(8'hce, 32'h0000_02a5);
		cyc(11);
		par_rd <= 1'b1;
		par_num <= 8'hd0;
		cyc(2);
		chk(par_rdata_ff, 32'h0000_002a);
		par_rd <= 1'b0;
		cyc(1);
		chk(par_rdata_ff, 32'h0000_00aa);
	endtask
	task t_encoder;
		wr(8'hd1, 32'hffff_fffe);
		enc_go <= 1'b1;
		cyc(10);
		enc_go <= 1'b0;
		cyc(3);
		rd(8'hd1, 32'h0000_0003);
		wr(8'hd2, 32'h0000_8000);
		rd(8'hd2, 32'h0000_8000);
		enc_go <= 1'b1;
		cyc(8);
		enc_go <= 1'b0;
		cyc(3);
		rd(8'hd1, 32'h0000_0005);
	endtask
	task t_errors;
		stall_event <= 1'b1;
		cyc(1);
		stall_event <= 1'b0;
		wr(8'hcf, 32'h0000_0003);
		rd(8'hcf, 32'h0000_0001);
		rd(8'hcf, 32'h0000_0000);
		stall_event <= 1'b1;
		cyc(1);
		stall_event <= 1'b0;
		motion_cmd <= 1'b1;
		cyc(1);
		motion_cmd <= 1'b0;
		rd(8'hcf, 32'h0000_0000);
		wr(8'hd4, 32'h0000_0005);
		cmd_position <= 32'h0000_0064;
		cyc(2);
		chk({31'h0, dev_stop_ff}, 32'h0000_0001);
		cyc(1);
		chk({31'h0, dev_stop_ff}, 32'h0000_0000);
		rd(8'hcf, 32'h0000_0002);
	endtask
	task print_verdict;
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(16);
		rst_n <= 1'b1;
		cyc(1);
		t_boost;
		t_freewheel;
		t_status;
		t_encoder;
		t_errors;
		print_verdict;
	end
	// Watchdog
	initial begin
		repeat (2000) @(posedge sys_clk);
		miscompares++;
		print_verdict;
	end
endmodule
bind stepper_axis_status_params axis_params_monitor mon (.sys_clk, .rst_n,
	.par_rd, .par_num, .par_rdata_ff, .ramping, .vel_zero, .run_current,
	.stall_load, .drv_flags, .step_pulse, .motor_current_ff, .power_cut_ff,
	.dev_stop_ff);
`default_nettype wire
